/* File: rtl/lp_cal_scheduler.sv */
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "lp_cal_params.svh"
module lp_cal_scheduler
  import lp_cal_pkg::*;
#(
  parameter int CNT_WIDTH = 41
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [9:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [9:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             cal_trigger_input,
  input  wire logic [3:0]       factory_ref_trim,
  input  wire logic             cal_done,
  output logic                  core_sleep,
  output logic                  core_cal_start,
  output logic [7:0]            core_gain_trim,
  output logic [3:0]            reference_trim
);
  import lp_cal_pkg::*;

  reg8_t            lowpower_cal_control;
  logic             trigger_source_select;
  logic             software_trigger_bit;
  logic             background_cal_enable;
  logic             trig_meta;
  logic             trig_sync;
  logic             aw_held;
  logic             w_held;
  logic [7:0]       aw_index;
  logic [7:0]       w_byte;
  logic             w_lane0;
  logic             do_write;
  sched_state_t     state;
  logic             cal_level;
  logic             lp_active;
  logic             ctr_load;
  logic [CNT_WIDTH-1:0] ctr_value;
  logic             ctr_run;
  logic             ctr_expired;
  logic             ref_loaded;

  // ========================================================================
  // Helpers
  function automatic logic [CNT_WIDTH-1:0] sleep_count(input logic [2:0] c);
    logic [40:0] v;
    v = `SLEEP_CNT_6;
    case (c)
      3'h0: v = `SLEEP_CNT_0;
      3'h1: v = `SLEEP_CNT_1;
      3'h2: v = `SLEEP_CNT_2;
      3'h3: v = `SLEEP_CNT_3;
      3'h4: v = `SLEEP_CNT_4;
      3'h5: v = `SLEEP_CNT_5;
      default: v = `SLEEP_CNT_6; // Code 7 undocumented, longest taken
    endcase
    return CNT_WIDTH'(v);
  endfunction

  function automatic logic [CNT_WIDTH-1:0] wake_count(input logic [1:0] c);
    logic [40:0] v;
    v = `WAKE_CNT_0;
    case (c)
      2'h0: v = `WAKE_CNT_0;
      2'h1: v = `WAKE_CNT_1;
      2'h2: v = `WAKE_CNT_2;
      default: v = `WAKE_CNT_3;
    endcase
    return CNT_WIDTH'(v);
  endfunction

  function automatic logic [7:0] word_index(input logic [9:0] a);
    return a[9:2];
  endfunction

  // ========================================================================
  // Trigger pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
    end else begin
      trig_meta <= cal_trigger_input;
      trig_sync <= trig_meta;
    end
  end

  // Trigger level source
  assign cal_level = trigger_source_select ? trig_sync
                                           : software_trigger_bit;
  // Low power active only under background calibration
  assign lp_active = background_cal_enable &&
                     lowpower_cal_control[`LP_ENABLE_BIT];

  // ========================================================================
  // AXI write channel: address and data taken in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_index      <= 8'h00;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held  <= 1'b1;
        aw_index <= word_index(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_index)
          `IDX_LP_CONTROL, `IDX_GAIN_TRIM, `IDX_REF_TRIM,
          `IDX_TRIG_CONFIG, `IDX_SOFT_TRIG, `IDX_BG_CONTROL,
          `IDX_SCHED_STATUS: s_axi_bresp <= 2'h0;
          default:           s_axi_bresp <= 2'h2; // Unmapped: SLVERR
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Register file; reserved bit 2 of lowpower_cal_control stored as written, software keeps zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lowpower_cal_control  <= `RST_LP_CONTROL;
      core_gain_trim        <= `RST_GAIN_TRIM;
      trigger_source_select <= `RST_TRIG_CONFIG;
      software_trigger_bit  <= `RST_SOFT_TRIG;
      background_cal_enable <= `RST_BG_CONTROL;
    end else if (do_write && w_lane0) begin
      case (aw_index)
        `IDX_LP_CONTROL:  lowpower_cal_control  <= w_byte;
        `IDX_GAIN_TRIM:   core_gain_trim        <= w_byte;
        `IDX_TRIG_CONFIG: trigger_source_select <= w_byte[0];
        `IDX_SOFT_TRIG:   software_trigger_bit  <= w_byte[0];
        `IDX_BG_CONTROL:  background_cal_enable <= w_byte[0];
        default: ;
      endcase
    end
  end

  // Reference trim: factory value caught on first clock after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_loaded     <= 1'b0;
      reference_trim <= `RST_REF_TRIM;
    end else if (!ref_loaded) begin
      ref_loaded     <= 1'b1;
      reference_trim <= factory_ref_trim;
    end else if (do_write && w_lane0 && aw_index == `IDX_REF_TRIM) begin
      reference_trim <= w_byte[`REF_TRIM_MSB:0];
    end
  end

  // ========================================================================
  // AXI read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        // Status shows the synced pin, not the selected trigger level
        case (word_index(s_axi_araddr))
          `IDX_LP_CONTROL:   s_axi_rdata <= {24'h0, lowpower_cal_control};
          `IDX_GAIN_TRIM:    s_axi_rdata <= {24'h0, core_gain_trim};
          `IDX_REF_TRIM:     s_axi_rdata <= {28'h0, reference_trim};
          `IDX_TRIG_CONFIG:  s_axi_rdata <= {31'h0, trigger_source_select};
          `IDX_SOFT_TRIG:    s_axi_rdata <= {31'h0, software_trigger_bit};
          `IDX_BG_CONTROL:   s_axi_rdata <= {31'h0, background_cal_enable};
          `IDX_SCHED_STATUS: s_axi_rdata <= {29'h0, trig_sync, state};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Scheduler: online core sleeps, then settles, calibrates, sleeps again
  always_comb begin
    ctr_load  = 1'b0;
    ctr_value = sleep_count(lowpower_cal_control[`SLEEP_SEL_MSB:
                                                 `SLEEP_SEL_LSB]);
    ctr_run   = (state == ST_SLEEP &&
                 !lowpower_cal_control[`TRIG_MODE_BIT]) ||
                state == ST_SETTLE;
    case (state)
      ST_ONLINE: ctr_load = lp_active;
      ST_CALIB:  ctr_load = cal_done;
      ST_SLEEP: begin
        ctr_load  = 1'b1;
        ctr_value = wake_count(lowpower_cal_control[`WAKE_SEL_MSB:
                                                    `WAKE_SEL_LSB]);
        ctr_load  = ctr_expired ||
                    (lowpower_cal_control[`TRIG_MODE_BIT] && !cal_level);
      end
      default: ctr_load = 1'b0;
    endcase
  end

  lp_delay_counter #(
    .WIDTH (CNT_WIDTH)
  ) u_delay (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .load       (ctr_load),
    .load_value (ctr_value),
    .run        (ctr_run),
    .expired    (ctr_expired)
  );

  // State moves; dropping low power returns the core online at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_ONLINE;
    end else if (!lp_active) begin
      state <= ST_ONLINE;
    end else begin
      case (state)
        ST_ONLINE: state <= ST_SLEEP;
        ST_SLEEP: begin
          if (lowpower_cal_control[`TRIG_MODE_BIT]) begin
            if (!cal_level) state <= ST_SETTLE;
          end else if (ctr_expired) begin
            state <= ST_SETTLE;
          end
        end
        ST_SETTLE: if (ctr_expired) state <= ST_CALIB;
        ST_CALIB:  if (cal_done) state <= ST_SLEEP;
        default:   state <= ST_ONLINE;
      endcase
    end
  end

  // Core controls registered for clean outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_sleep     <= 1'b0;
      core_cal_start <= 1'b0;
    end else begin
      core_sleep     <= lp_active && state == ST_SLEEP;
      core_cal_start <= lp_active && state == ST_SETTLE && ctr_expired;
    end
  end
endmodule

/* File: rtl/lp_cal_params.svh */
`ifndef LP_CAL_PARAMS_SVH
`define LP_CAL_PARAMS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define IDX_LP_CONTROL     8'h6E
`define IDX_GAIN_TRIM      8'h7A
`define IDX_REF_TRIM       8'h7C
`define IDX_TRIG_CONFIG    8'h6B
`define IDX_SOFT_TRIG      8'h6C
`define IDX_BG_CONTROL     8'h62
`define IDX_SCHED_STATUS   8'h63

// ==========================================================================
// Field positions in lowpower_cal_control and the reference trim register
`define SLEEP_SEL_MSB      7
`define SLEEP_SEL_LSB      5
`define WAKE_SEL_MSB       4
`define WAKE_SEL_LSB       3
`define TRIG_MODE_BIT      1
`define LP_ENABLE_BIT      0
`define REF_TRIM_MSB       3

// ==========================================================================
// Reset values
`define RST_LP_CONTROL     8'h88
`define RST_GAIN_TRIM      8'h00
`define RST_SOFT_TRIG      1'b1
`define RST_REF_TRIM       4'h0
`define RST_TRIG_CONFIG    1'b0
`define RST_BG_CONTROL     1'b0

// ==========================================================================
// Delay counts in sample-clock periods
`define SLEEP_CNT_0        41'h000_0000_0480
`define SLEEP_CNT_1        41'h000_0040_0080
`define SLEEP_CNT_2        41'h000_0200_0080
`define SLEEP_CNT_3        41'h000_1000_0080
`define SLEEP_CNT_4        41'h000_8000_0080
`define SLEEP_CNT_5        41'h020_0000_0080
`define SLEEP_CNT_6        41'h100_0000_0080
`define WAKE_CNT_0         41'h000_0000_0480
`define WAKE_CNT_1         41'h000_0200_0080
`define WAKE_CNT_2         41'h000_1000_0080
`define WAKE_CNT_3         41'h000_8000_0080

`endif

/* File: rtl/lp_cal_pkg.sv */
package lp_cal_pkg;
  typedef enum logic [1:0] {
    ST_ONLINE,
    ST_SLEEP,
    ST_SETTLE,
    ST_CALIB
  } sched_state_t;
  typedef logic [7:0] reg8_t;
endpackage

/* File: rtl/lp_delay_counter.sv */
`timescale 1ns/1ps
`include "lp_cal_params.svh"
// ==========================================================================
// Down counter for sleep and settle delays
module lp_delay_counter #(
  parameter int WIDTH = 41
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             run,
  output logic                  expired
);
  logic [WIDTH-1:0] remaining;

  // Load wins over counting; expired is a level while running at one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remaining <= '0;
    end else if (load) begin
      remaining <= load_value;
    end else if (run && remaining != '0) begin
      remaining <= remaining - WIDTH'(1);
    end
  end

  assign expired = run && (remaining == WIDTH'(1));
endmodule

/* File: tb/lp_cal_properties.sv */
`timescale 1ns/1ps
// ==========================================================
// Bus and scheduler output checks
module lp_cal_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0]  factory_ref_trim,
  input wire logic        core_sleep,
  input wire logic        core_cal_start,
  input wire logic [7:0]  core_gain_trim,
  input wire logic [3:0]  reference_trim
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address phases still waiting for the slave
  sequence s_aw_wait; s_axi_awvalid && !s_axi_awready; endsequence
  sequence s_ar_wait; s_axi_arvalid && !s_axi_arready; endsequence
  a_aw_taken: assert property (s_aw_wait |-> ##[1:8] s_axi_awready)
    else $error("write address not accepted");
  a_ar_taken: assert property (s_ar_wait |-> ##[1:8] s_axi_arready)
    else $error("read address not accepted");
  // Only byte lane 0 carries data; refused reads return zero
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10
    |-> s_axi_rdata == 32'h0) else $error("error read not zero");
  a_start_pulse: assert property (core_cal_start |=> !core_cal_start)
    else $error("calibration start wider than one cycle");
  a_sleep_first: assert property ($rose(core_sleep)
    |-> (!core_cal_start)[*8])
    else $error("calibration started right after sleep");
  a_reset_outs: assert property ($rose(aresetn) |-> !core_sleep
    && !core_cal_start && core_gain_trim == 8'h00)
    else $error("outputs not at reset values");
  a_ref_load: assert property ($rose(aresetn)
    |=> reference_trim == $past(factory_ref_trim))
    else $error("factory trim not loaded");
endmodule

bind lp_cal_scheduler lp_cal_checker i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata,
  .factory_ref_trim, .core_sleep, .core_cal_start, .core_gain_trim,
  .reference_trim
);

/* File: tb/lp_far_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Trigger source and calibration engine stand-in
module lp_far_model #(
  parameter int CAL_CYCLES = 5
) (
  input  wire logic aclk,
  input  wire logic hold_asleep,
  input  wire logic core_cal_start,
  output logic      cal_trigger_input,
  output logic      cal_done
);
  int cnt;
  // Level held high keeps the core asleep, driven low to wake it
  assign cal_trigger_input = hold_asleep;
  // Calibration finishes a fixed time after each start pulse
  initial begin
    cnt = 0;
    cal_done = 1'b0;
  end
  always @(posedge aclk) begin
    cal_done <= (cnt == 1);
    if (core_cal_start) cnt <= CAL_CYCLES;
    else if (cnt != 0) cnt <= cnt - 1;
  end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "lp_cal_params.svh"
// ==========================================================
// Bench top
module tb_top;
  import lp_cal_pkg::*;
  localparam logic [9:0] A_CTRL = {`IDX_LP_CONTROL, 2'b00};
  localparam logic [9:0] A_GAIN = {`IDX_GAIN_TRIM, 2'b00};
  localparam logic [9:0] A_REF = {`IDX_REF_TRIM, 2'b00};
  localparam logic [9:0] A_SRC = {`IDX_TRIG_CONFIG, 2'b00};
  localparam logic [9:0] A_SOFT = {`IDX_SOFT_TRIG, 2'b00};
  localparam logic [9:0] A_BG = {`IDX_BG_CONTROL, 2'b00};
  localparam logic [9:0] A_STAT = {`IDX_SCHED_STATUS, 2'b00};
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, hold_asleep, cal_trigger_input;
  logic        cal_done, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, core_sleep, core_cal_start;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb, fac, reference_trim;
  logic [7:0]  rnd, core_gain_trim;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [33:0] exp_q[$];
  logic [1:0]  bexp_q[$];
  int          miscompares, checks_done, starts, n, s0;
  int          seed = 33557;

  lp_cal_scheduler i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cal_trigger_input, .factory_ref_trim(fac), .cal_done, .core_sleep,
    .core_cal_start, .core_gain_trim, .reference_trim
  );
  lp_far_model i_far (
    .aclk, .hold_asleep, .core_cal_start, .cal_trigger_input, .cal_done
  );

  // ==========================================================
  // Clock, verdict and result checking
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic final_report;
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read answers are matched to the oldest note; start pulses counted
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata},
      exp_q.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp),
      34'(bexp_q.pop_front()));
    if (core_cal_start === 1'b1) starts++;
  end
  // Hang guard, well beyond the expected run of about 8000 cycles
  initial begin
    #3_000_000;
    miscompares++;
    final_report;
  end

  // ==========================================================
  // Bus cycles; each starts one edge later so no signal is set twice
  task automatic wr(input logic [9:0] a, input logic [7:0] d,
                    input logic [1:0] eb = 2'b00);
    logic ka, kw;
    ka = 1'b0;
    kw = 1'b0;
    bexp_q.push_back(eb);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(ka && kw)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ka = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        kw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [33:0] e);
    @(posedge aclk);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  // Cycles until the next calibration start, bounded
  task automatic wait_start(input int lim);
    n = 0;
    while (core_cal_start !== 1'b1 && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, hold_asleep} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    fac = 4'($random(seed));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_CTRL, 34'h88);
    rd(A_GAIN, 34'h0);
    rd(A_REF, 34'(fac));
    rd(10'h3FC, {2'b10, 32'h0});
    wr(10'h3FC, 8'h5A, 2'b10);
    rd(A_SOFT, 34'h1);
    rd(A_SRC, 34'h0);
    // Random values written and read back; gain and reference trim also seen at the outputs
    rnd = 8'($random(seed));
    wr(A_GAIN, rnd);
    rd(A_GAIN, 34'(rnd));
    chk(34'(core_gain_trim), 34'(rnd));
    // Lane 0 strobe low: the write is answered but stores nothing
    s_axi_wstrb <= 4'hE;
    wr(A_GAIN, ~rnd);
    s_axi_wstrb <= 4'hF;
    rd(A_GAIN, 34'(rnd));
    wr(A_REF, {4'h0, rnd[3:0]});
    rd(A_REF, 34'(rnd[3:0]));
    chk(34'(reference_trim), 34'(rnd[3:0]));
    rnd = rnd | 8'h88;
    wr(A_CTRL, {rnd[7:3], 3'b000});
    rd(A_CTRL, 34'({rnd[7:3], 3'b000}));
    // Enable alone does nothing while background calibration is off
    wr(A_CTRL, 8'h01);
    repeat (50) @(posedge aclk);
    chk(34'(core_sleep), 34'h0);
    // Autonomous: shortest sleep then shortest settle
    wr(A_BG, 8'h01);
    while (core_sleep !== 1'b1) @(posedge aclk);
    wait_start(3000);
    chk(34'(n >= 2294 && n <= 2314), 34'h1);
    // Trigger held sleep: soft bit first (pin low, ignored), then pin
    for (int src = 0; src < 2; src++) begin
      wr(A_CTRL, 8'h00);
      wr(A_SRC, 8'(src));
      wr(A_SOFT, 8'h01);
      hold_asleep <= (src == 1);
      wr(A_CTRL, 8'h03);
      s0 = starts;
      repeat (1500) @(posedge aclk);
      chk(34'(core_sleep), 34'h1);
      chk(34'(starts - s0), 34'h0);
      rd(A_STAT, 34'({src[0], 2'b01}));
      if (src == 1) hold_asleep <= 1'b0;
      else wr(A_SOFT, 8'h00);
      wait_start(1300);
      chk(34'(n < 1180), 34'h1);
    end
    final_report;
  end
endmodule
